// ---- design/wbm_master.sv ----
// Bus master port: turns user block requests into bus cycles.
// Assumes a same-clock user side and a fabric that answers each strobe.
`include "wbm_defs.svh"

module wbm_master #(
   parameter int PORT_BITS = `WBM_PORT_BITS,   // [R6]
   parameter int GRAN_BITS = `WBM_GRAN_BITS,   // [R7]
   parameter int ADDR_BITS = `WBM_ADDR_BITS,
   parameter int TAG_BITS  = `WBM_TAG_BITS
) (
   // System
   input  wire logic                          core_clk,
   input  wire logic                          rstn,
   // Bus reset, active high from the system controller
   input  wire logic                          rst_i,
   // User request side
   input  wire logic                          req_valid,
   output logic                               req_ready,
   input  wire wbm_pkg::wbm_req_t             req,
   input  wire wbm_pkg::wbm_beat_t            wr_beat,
   output logic                               wr_take,
   output logic                               rd_valid,
   output wbm_pkg::wbm_beat_t                 rd_beat,
   output logic                               done,
   // Bus side
   output logic                               cyc_o,
   output logic                               stb_o,
   output logic                               we_o,
   output logic [ADDR_BITS-1:$clog2(PORT_BITS/GRAN_BITS)] adr_o,
   output logic [PORT_BITS/GRAN_BITS-1:0]     sel_o,
   output logic [PORT_BITS-1:0]               dat_o,
   output logic [TAG_BITS-1:0]                tgd_o,
   input  wire logic [PORT_BITS-1:0]          dat_i,
   input  wire logic [TAG_BITS-1:0]           tgd_i,
   input  wire logic                          ack_i
);

   localparam int LSB = $clog2(PORT_BITS / GRAN_BITS);   // [R8]
   localparam int AW  = ADDR_BITS - LSB;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   // Control group: cleared by either reset.
   wbm_pkg::wbm_state_t               state_reg,  state_next;
   logic                              cyc_reg,    cyc_next;
   logic                              stb_reg,    stb_next;
   logic                              we_reg,     we_next;
   logic [`WBM_LEN_BITS-1:0]          left_reg,   left_next;
   logic                              rdv_reg,    rdv_next;
   logic                              done_reg,   done_next;
   // Data path group: cleared only by the system reset.
   logic [ADDR_BITS-1:LSB]            adr_reg,    adr_next;
   logic [PORT_BITS-1:0]              dato_reg,   dato_next;
   logic [TAG_BITS-1:0]               tgdo_reg,   tgdo_next;
   wbm_pkg::wbm_beat_t                rdb_reg,    rdb_next;
   // Events: the qualified acknowledge, and those handed from the control group to the data path.
   logic                              ack_seen;
   logic                              start_go;
   logic                              beat_go;
   logic                              rd_cap;

   // Acknowledge counts only inside an own strobed transfer.
   assign ack_seen = cyc_reg & stb_reg & ack_i;   // [R18] [R12]

   // ------------------------------------------------------------------
   // Control next state
   // ------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cyc_next   = cyc_reg;
      stb_next   = stb_reg;
      we_next    = we_reg;
      left_next  = left_reg;
      rdv_next   = 1'h0;
      done_next  = 1'h0;
      req_ready  = 1'h0;
      wr_take    = 1'h0;
      start_go   = 1'h0;
      beat_go    = 1'h0;
      rd_cap     = 1'h0;
      unique case (state_reg)
         wbm_pkg::WBM_IDLE: begin
            req_ready = 1'h1;
            if (req_valid && req.count != `WBM_ZERO_LEN) begin
               // Cycle valid rises with the first transfer and asks the arbiter.
               cyc_next   = 1'h1;   // [R10] [R11]
               stb_next   = 1'h1;   // [R16]
               we_next    = req.write;
               left_next  = req.count;
               wr_take    = req.write;
               start_go   = 1'h1;
               state_next = wbm_pkg::WBM_XFER;
            end
         end
         wbm_pkg::WBM_XFER: begin
            if (ack_seen) begin   // [R12]
               rdv_next = !we_reg;
               rd_cap   = !we_reg;
               if (left_reg == `WBM_ONE_LEN) begin
                  // Cycle valid drops only after the last transfer ends.
                  cyc_next   = 1'h0;   // [R10]
                  stb_next   = 1'h0;
                  state_next = wbm_pkg::WBM_DONE;
               end else begin
                  left_next = left_reg - `WBM_ONE_LEN;
                  wr_take   = we_reg;
                  beat_go   = 1'h1;
               end
            end
         end
         wbm_pkg::WBM_DONE: begin
            done_next  = 1'h1;
            state_next = wbm_pkg::WBM_IDLE;
         end
         default: begin
            // An unused state code falls back to idle with the bus released.
            cyc_next   = 1'h0;
            stb_next   = 1'h0;
            state_next = wbm_pkg::WBM_IDLE;
         end
      endcase
      // The bus reset wins over a request or an acknowledge in the same cycle,
      // so no request is accepted and then silently lost.
      if (rst_i) begin   // [R3] [R5]
         state_next = wbm_pkg::WBM_IDLE;   // [R3]
         cyc_next   = 1'h0;   // [R19]
         stb_next   = 1'h0;   // [R19] [R17]
         we_next    = 1'h0;
         left_next  = `WBM_ZERO_LEN;
         rdv_next   = 1'h0;
         done_next  = 1'h0;
         req_ready  = 1'h0;
         wr_take    = 1'h0;
         start_go   = 1'h0;
         beat_go    = 1'h0;
         rd_cap     = 1'h0;
      end
   end

   // ------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin   // [R2]
      if (!rstn) begin
         state_reg <= wbm_pkg::WBM_IDLE;
         cyc_reg   <= 1'h0;
         stb_reg   <= 1'h0;
         we_reg    <= 1'h0;
         left_reg  <= `WBM_ZERO_LEN;
         rdv_reg   <= 1'h0;
         done_reg  <= 1'h0;
      end else begin
         state_reg <= state_next;
         cyc_reg   <= cyc_next;
         stb_reg   <= stb_next;
         we_reg    <= we_next;
         left_reg  <= left_next;
         rdv_reg   <= rdv_next;
         done_reg  <= done_next;
      end
   end

   // ------------------------------------------------------------------
   // Data path next state
   // ------------------------------------------------------------------
   // The bus reset only clears the control group; address, data and tags stay.
   always_comb begin   // [R4]
      adr_next  = adr_reg;
      dato_next = dato_reg;
      tgdo_next = tgdo_reg;
      rdb_next  = rdb_reg;
      if (start_go) begin
         adr_next  = req.addr[ADDR_BITS-1:LSB];   // [R8]
         dato_next = wr_beat.data;   // [R13]
         tgdo_next = wr_beat.tag;    // [R13]
      end
      if (beat_go) begin
         adr_next  = adr_reg + AW'(`WBM_WORD_STEP);
         dato_next = wr_beat.data;
         tgdo_next = wr_beat.tag;
      end
      if (rd_cap) begin
         rdb_next.data = dat_i;   // [R2]
         rdb_next.tag  = tgd_i;   // [R13]
      end
   end

   // ------------------------------------------------------------------
   // Data path registers
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin   // [R2]
      if (!rstn) begin
         adr_reg  <= '0;
         dato_reg <= '0;
         tgdo_reg <= '0;
         rdb_reg  <= '0;
      end else begin
         adr_reg  <= adr_next;
         dato_reg <= dato_next;
         tgdo_reg <= tgdo_next;
         rdb_reg  <= rdb_next;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // Whole-word selects: largest operand taken equal to the port, so
   // byte order cannot matter here.
   assign sel_o    = '1;   // [R14] [R15]
   assign cyc_o    = cyc_reg;   // [R1]
   assign stb_o    = stb_reg;
   assign we_o     = we_reg;
   assign adr_o    = adr_reg;   // [R9]
   assign dat_o    = dato_reg;
   assign tgd_o    = tgdo_reg;
   assign rd_valid = rdv_reg;
   assign rd_beat  = rdb_reg;
   assign done     = done_reg;

endmodule // wbm_master

// ---- inc/wbm_defs.svh ----
// Constants for the bus master port: widths, lengths and reset values.
// Assumes inclusion by the package and the master module, one clock domain.
//
// Functional notes
// [R1] All bus signals are active high.
// [R2] Outputs registered, inputs sampled on rising edge.
// [R3] High reset restarts port and state machines.
// [R4] Reset need only clear the bus logic.
// [R5] One system module supplies clock and reset.
// [R6] Data arrays are 8, 16, 32 or 64 bits.
// [R7] Granularity is 8, 16, 32 or 64 bits.
// [R8] Address lower bound follows port size, granularity.
// [R9] Address array may be omitted for FIFO ports.
// [R10] Cycle valid held through every block transfer.
// [R11] Cycle valid doubles as arbiter bus request.
// [R12] Acknowledge marks normal transfer completion.
// [R13] Data tags follow data timing, strobe qualified.
// [R14] Unknown max operand equals the granularity; the code takes it equal to the port, with all selects high.
// [R15] Fixed byte order; equal when size equals granularity.
// [R16] Strobe marks each valid data transfer.
// [R17] Slave reacts only while strobe is high.
// [R18] Acknowledge sampled only with cycle and strobe.
// [R19] Cycle and strobe low while reset is high; the code clears them at the first clock edge that samples reset high.
`ifndef WBM_DEFS_SVH
`define WBM_DEFS_SVH

`define WBM_PORT_BITS   32
`define WBM_GRAN_BITS   8
`define WBM_ADDR_BITS   32
`define WBM_TAG_BITS    4
`define WBM_LEN_BITS    8
`define WBM_BIG_ENDIAN  1'h0
`define WBM_ZERO_LEN    8'h00
`define WBM_ONE_LEN     8'h01
`define WBM_WORD_STEP   1'h1

`endif

// ---- inc/wbm_pkg.sv ----
// Types shared by the bus master port.
// Assumes the constants header is on the include path.
`include "wbm_defs.svh"

package wbm_pkg;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      WBM_IDLE,
      WBM_XFER,
      WBM_DONE
   } wbm_state_t;

   // One user request: a block of count transfers from a start word.
   typedef struct packed {
      logic                         write;
      logic [`WBM_ADDR_BITS-1:0]    addr;
      logic [`WBM_LEN_BITS-1:0]     count;
   } wbm_req_t;

   // One data beat with its tag.
   typedef struct packed {
      logic [`WBM_TAG_BITS-1:0]     tag;
      logic [`WBM_PORT_BITS-1:0]    data;
   } wbm_beat_t;

endpackage

// ---- tb/wbm_chk.sv ----
// Checker on the bus master ports.
// Assumes one clock domain; bound to the master by the bench.
module wbm_chk (
   // System
   input wire logic              core_clk,
   input wire logic              rstn,
   input wire logic              rst_i,
   // User side
   input wire logic              req_valid,
   input wire logic              req_ready,
   input wire wbm_pkg::wbm_req_t req,
   input wire logic              rd_valid,
   input wire logic              done,
   // Bus side
   input wire logic              cyc_o,
   input wire logic              stb_o,
   input wire logic              ack_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------
   // Checks
   // ------
   logic acked;
   assign acked = cyc_o & stb_o & ack_i;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   a_rst_idle: assert property (rst_i |=> !cyc_o && !stb_o)
      else $error("bus busy after reset");
   a_cyc_hold: assert property (cyc_o && !ack_i && !rst_i |=> cyc_o)
      else $error("cycle dropped early");
   a_stb_cyc: assert property (stb_o |-> cyc_o)
      else $error("strobe outside cycle");
   a_req_start: assert property (req_valid && req_ready && req.count != 8'h00 && !rst_i
      |=> cyc_o && stb_o)
      else $error("cycle did not start");
   a_done_end: assert property ($fell(cyc_o) && !$past(rst_i) && !rst_i |-> ##[0:1] done)
      else $error("no done after cycle");
   a_ready_busy: assert property (cyc_o |-> !req_ready)
      else $error("ready during cycle");
   a_ack_ignored: assert property (ack_i && !cyc_o |=> !rd_valid)
      else $error("stray ack used");
   a_rd_cause: assert property (rd_valid |-> $past(acked))
      else $error("read data without ack");
   a_done_pulse: assert property (done |=> !done)
      else $error("done too long");
   c_block: cover property (acked ##1 cyc_o);
   c_stray: cover property (ack_i && !cyc_o);
   c_bus_rst: cover property (rst_i && cyc_o);
endmodule // wbm_chk

// ---- tb/wbm_slave.sv ----
// Fabric and slave model answering each strobe after lat idle cycles.
// Assumes 32-bit data, 4-bit tags and the master's clock.
module wbm_slave (
   // System
   input wire logic        core_clk,
   input wire logic        rstn,
   input wire logic        rst_i,
   // From the master
   input wire logic        cyc_o,
   input wire logic        stb_o,
   input wire logic        we_o,
   input wire logic [31:2] adr_o,
   input wire logic [31:0] dat_o,
   input wire logic [3:0]  tgd_o,
   // Test controls
   input wire logic [31:0] lat,
   input wire logic        stray,
   // To the master
   output logic            ack_i = 1'b0,
   output logic [31:0]     dat_i = 32'h0,
   output logic [3:0]      tgd_i = 4'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------
   // Responder
   // ---------
   // Data lines toggle while not answering, so early sampling reads garbage.
   logic [35:0] mem [int];
   int          cnt;
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ack_i <= 1'b0;
         cnt = 0;
      end else if (rst_i) begin
         ack_i <= 1'b0;
         cnt = 0;
      end else if (cyc_o && stb_o && !ack_i && cnt >= lat) begin
         ack_i <= 1'b1;
         cnt = 0;
         if (we_o) mem[int'(adr_o)] = {tgd_o, dat_o};
         else {tgd_i, dat_i} <= mem[int'(adr_o)];
      end else begin
         ack_i <= stray && !cyc_o;
         cnt = (cyc_o && stb_o && !ack_i) ? cnt + 1 : 0;
         {tgd_i, dat_i} <= ~{tgd_i, dat_i};
      end
   end
endmodule // wbm_slave

// ---- tb/tb.sv ----
// Bench: drives the master, models the fabric, checks every beat.
// Assumes the package, checker and slave model are compiled first.
`define CHK(nm, e, s) begin n_checks++; if ((e) !== (s)) begin errors++; \
   $display("[ERR] %s expected %h seen %h", nm, e, s); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, rstn = 1'b0, rst_i = 1'b0, req_valid = 1'b0, stray = 1'b0;
   logic ack_i, req_ready, wr_take, rd_valid, done, cyc_o, stb_o, we_o, exp_we;
   logic [31:2] adr_o, exp_adr;
   logic [3:0]  sel_o, tgd_o, tgd_i;
   logic [31:0] dat_o, dat_i;
   logic [35:0] wb, model [int], wq [$], rq [$];
   wbm_pkg::wbm_req_t  req = '0;
   wbm_pkg::wbm_beat_t wr_beat = '0, rd_beat;
   int errors = 0, n_checks = 0, seed = 32'h0c6d, lat = 0, cycles = 0, k, t, tagc = 0;
   always #2.5 core_clk = ~core_clk;
   wbm_master dut (.core_clk, .rstn, .rst_i, .req_valid, .req_ready, .req, .wr_beat,
      .wr_take, .rd_valid, .rd_beat, .done, .cyc_o, .stb_o, .we_o, .adr_o, .sel_o,
      .dat_o, .tgd_o, .dat_i, .tgd_i, .ack_i);
   wbm_slave u_slv (.core_clk, .rstn, .rst_i, .cyc_o, .stb_o, .we_o, .adr_o, .dat_o, .tgd_o,
      .lat, .stray, .ack_i, .dat_i, .tgd_i);
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [7:0] n);
      req <= {w, 32'h0000_0100, n};
      req_valid <= 1'b1;
      do @(posedge core_clk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      t = 0;
      do @(posedge core_clk); while (done !== 1'b1 && ++t < 1200);
      `CHK("done", 1'b1, done)
   endtask
   // Model: expected address, write beats in order, read data from written words.
   always @(posedge core_clk) begin
      if (++cycles == 6000) begin
         errors++;
         tally_and_finish();
      end
      if (req_valid && req_ready && req.count != 8'h00) begin
         exp_adr <= req.addr[31:2];
         exp_we <= req.write;
      end
      if (wr_take) begin
         wq.push_back(wr_beat);
         wr_beat <= {tagc[3:0], $random(seed)};
         tagc++;
      end
      if (cyc_o && stb_o && ack_i) begin
         `CHK("adr", exp_adr, adr_o)
         `CHK("we", exp_we, we_o)
         `CHK("sel", 4'hF, sel_o)
         exp_adr <= exp_adr + 30'h1;
         if (exp_we) begin
            wb = wq.pop_front();
            `CHK("wdat", wb, {tgd_o, dat_o})
            model[int'(exp_adr)] = wb;
         end else rq.push_back(model[int'(exp_adr)]);
      end
      if (rd_valid) begin
         wb = rq.pop_front();
         `CHK("rdat", wb, rd_beat)
      end
   end
   initial begin
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      for (k = 0; k < 8; k++) begin
         lat <= {$random(seed)} % 4;
         xfer(1'b1, 8'(k + 1));
         xfer(1'b0, 8'(k + 1));
      end
      lat <= 0;
      xfer(1'b1, 8'hFF);
      xfer(1'b0, 8'hFF);
      req <= {1'b0, 32'h0000_0100, 8'h00};
      req_valid <= 1'b1;
      repeat (3) @(posedge core_clk);
      `CHK("cyc", 1'b0, cyc_o)
      req_valid <= 1'b0;
      stray <= 1'b1;
      @(posedge core_clk);
      stray <= 1'b0;
      repeat (2) @(posedge core_clk);
      `CHK("rdv", 1'b0, rd_valid)
      // Bus reset in the middle of a slow write: the cycle must be dropped.
      lat <= 20;
      req <= {1'b1, 32'h0000_0100, 8'h04};
      req_valid <= 1'b1;
      @(posedge core_clk);
      req_valid <= 1'b0;
      repeat (5) @(posedge core_clk);
      `CHK("cyc", 1'b1, cyc_o)
      rst_i <= 1'b1;
      @(posedge core_clk);
      rst_i <= 1'b0;
      @(posedge core_clk);
      `CHK("cyc", 1'b0, cyc_o)
      wq.delete();
      lat <= 1;
      xfer(1'b1, 8'h02);
      xfer(1'b0, 8'h02);
      tally_and_finish();
   end
endmodule // tb
bind wbm_master wbm_chk u_chk (.core_clk, .rstn, .rst_i, .req_valid, .req_ready, .req,
   .rd_valid, .done, .cyc_o, .stb_o, .ack_i);
